/* include/slvc_pkg.sv */
package slvc_pkg;

   // Clock and derived cycle counts
   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned CLK_PERIOD_NS = 25;

   // Analog ramp and sleep times in microseconds; plain defaults
   localparam int unsigned SOFT_RISE_TIME_US = 10000;
   localparam int unsigned SOFT_FALL_TIME_US = 10000;
   localparam int unsigned HARD_RISE_TIME_US = 1000;
   localparam int unsigned HARD_FALL_TIME_US = 1000;
   localparam int unsigned SLEEP_PROCESSING_TIME_US = 200;
   localparam int unsigned WDT_TIMEOUT_US = 100000;
   localparam int unsigned SOFT_RISE_CYC = SOFT_RISE_TIME_US * CLK_MHZ;
   localparam int unsigned SOFT_FALL_CYC = SOFT_FALL_TIME_US * CLK_MHZ;
   localparam int unsigned HARD_RISE_CYC = HARD_RISE_TIME_US * CLK_MHZ;
   localparam int unsigned HARD_FALL_CYC = HARD_FALL_TIME_US * CLK_MHZ;
   localparam int unsigned SLEEP_PROC_CYC = SLEEP_PROCESSING_TIME_US * CLK_MHZ;
   localparam int unsigned WDT_TIMEOUT_CYC = WDT_TIMEOUT_US * CLK_MHZ;
   localparam int CNT_W = 32;

   // Register bus
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_ANALOG = 8'h08;
   localparam logic [ADDR_W-1:0] REG_GAIN_FADE = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_FADE_TIME = 8'h10;
   localparam logic [ADDR_W-1:0] REG_WDT = 8'h14;

   // Command bytes and masks
   localparam logic [7:0] WAKE_MASK = 8'hfe;
   localparam logic [7:0] WAKE_CODE = 8'h00;
   localparam logic [7:0] ANALOG_MASK = 8'hfc;
   localparam logic [7:0] ANALOG_CODE = 8'h04;
   localparam logic [7:0] GAIN_CODE = 8'h08;
   localparam logic [7:0] FADE_CODE = 8'h0c;
   localparam logic [7:0] WDT_CODE = 8'h14;
   localparam logic [7:0] SLEEP_CODE = 8'h20;
   localparam logic [7:0] GAIN_ZERO_MASK = 8'hc3;
   localparam logic [7:0] FADE_ZERO_MASK = 8'hf0;
   localparam int GAIN_LSB = 2;
   localparam logic [3:0] GAIN_BAD_1 = 4'h1;
   localparam logic [3:0] GAIN_BAD_2 = 4'h2;
   localparam logic [3:0] GAIN_DEFAULT = 4'h8;
   localparam logic [2:0] FADE_STEP_DEFAULT = 3'h0;
   localparam logic FADE_EN_DEFAULT = 1'b0;

   // Fade arithmetic
   localparam int unsigned FADE_NUM = 264;
   localparam int unsigned FADE_DEN_SHIFT = 8;
   localparam int unsigned FADE_ROUND = 255;
   localparam logic [7:0] FADE_FULL_STEP = 8'h80;
   localparam int unsigned GROUP_NS_0 = 23440;
   localparam int unsigned GROUP_NS_1 = 39060;
   localparam int unsigned GROUP_NS_2 = 31250;
   localparam int unsigned GROUP_NS_3 = 22680;
   localparam int unsigned GROUP_NS_4 = 20830;

   typedef enum logic [1:0] {
      PWR_STANDBY = 2'b00,
      PWR_SLEEP_WAIT = 2'b01,
      PWR_SLEEP = 2'b11
   } slvc_pwr_t;

   typedef enum logic [1:0] {
      AMP_OFF = 2'b00,
      AMP_RISE = 2'b01,
      AMP_ON = 2'b11,
      AMP_FALL = 2'b10
   } slvc_amp_t;

   typedef enum logic [1:0] {
      PARSE_IDLE = 2'b00,
      PARSE_SECOND = 2'b01,
      PARSE_SKIP = 2'b11
   } slvc_parse_t;

   typedef struct packed {
      logic amp_class_select;
      logic hpf_on;
      logic fade_on_stop;
      logic [1:0] dac_gain;
      logic [1:0] ain_gain;
      logic line_amp_enable;
      logic spk_amp_enable;
      logic pop_suppress;
   } slvc_analog_t;

   localparam slvc_analog_t ANALOG_DEFAULT = '0;

   // Further bytes that follow a first byte of any command
   function automatic logic [1:0] slvc_extra_bytes(input logic [7:0] b);
      logic [1:0] n;
      n = 2'd0;
      if (b[7:4] == 4'h3 || b[7:4] == 4'h4 || b[7:4] == 4'h7 || b[7:4] == 4'ha)
         n = 2'd1;
      if (b == 8'hc4 || b == 8'hc8)
         n = 2'd2;
      if ((b & ANALOG_MASK) == ANALOG_CODE || b == GAIN_CODE || b == FADE_CODE)
         n = 2'd1;
      return n;
   endfunction

endpackage

/* src/slvc_fade_timer.sv */
`timescale 1ns/1ps
module slvc_fade_timer
   import slvc_pkg::*;
(
   input wire logic [2:0] step_code_in,
   input wire logic [6:0] vol_old_in,
   input wire logic [6:0] vol_new_in,
   input wire logic [2:0] rate_family_in,
   output logic [7:0] step_size_out,
   output logic [31:0] transition_ns_out
);

   logic [6:0] vol_diff;
   logic [15:0] factor_raw;
   logic [7:0] factor;
   logic [15:0] group_ns;
   logic [31:0] product;

   assign step_size_out = FADE_FULL_STEP >> step_code_in;
   assign vol_diff = (vol_old_in > vol_new_in) ? (vol_old_in - vol_new_in)
                                                : (vol_new_in - vol_old_in);
   // Per-step factor 264 / (256 / 2^n), rounded up
   assign factor_raw = (16'(FADE_NUM) << step_code_in) + 16'(FADE_ROUND);
   assign factor = 8'(factor_raw >> FADE_DEN_SHIFT);
   assign group_ns = (rate_family_in == 3'd0) ? 16'(GROUP_NS_0) :
                     (rate_family_in == 3'd1) ? 16'(GROUP_NS_1) :
                     (rate_family_in == 3'd2) ? 16'(GROUP_NS_2) :
                     (rate_family_in == 3'd3) ? 16'(GROUP_NS_3) :
                     16'(GROUP_NS_4);
   assign product = 32'(vol_diff) * 32'(factor) * 32'(group_ns);
   assign transition_ns_out = product;

endmodule

/* src/slvc_cmd_core.sv */
`timescale 1ns/1ps
// Overview of operation
// - Pop bit acts only in line mode
// - Suppressed line ramps use soft times
// - Unsuppressed line ramps use hard times
// - Speaker mode: 00 off, 01 on
// - Line mode: 10 on, 00 off
// - Gain command: 08h then gain code bits 5:2
// - Gain codes map; 8 default, 1-2 prohibited
// - Gain kept on stop, reset on sleep
// - Gain, fade, watchdog ignore command-ready
// - Fade command: 0Ch, step bits 3:1, enable bit 0
// - Step size 128/2^n per group period
// - Transition time from volume difference and factor
// - Factor rounded up; five group periods
// - Watchdog clear restarts the counter
// - Sleep command enters sleep, defaults settings
// - Sleep ignored while any channel busy
// - Oscillator stops after sleep processing time
// - In sleep only wake command accepted
// - Analog setup field layout, pop at bit 0
// - Analog setup ignored in sleep, ramps, playback
module slvc_cmd_core
   import slvc_pkg::*;
#(
   parameter int unsigned SOFT_RISE_CYCLES = SOFT_RISE_CYC,
   parameter int unsigned SOFT_FALL_CYCLES = SOFT_FALL_CYC,
   parameter int unsigned HARD_RISE_CYCLES = HARD_RISE_CYC,
   parameter int unsigned HARD_FALL_CYCLES = HARD_FALL_CYC,
   parameter int unsigned SLEEP_PROC_CYCLES = SLEEP_PROC_CYC,
   parameter int unsigned WDT_TIMEOUT_CYCLES = WDT_TIMEOUT_CYC
)
(
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic [ADDR_W-1:0] bus_addr_in,
   input wire logic [DATA_W-1:0] bus_wdata_in,
   input wire logic bus_wr_in,
   input wire logic bus_rd_in,
   output logic [DATA_W-1:0] bus_rdata_out,
   input wire logic [3:0] channel_busy_n_in,
   input wire logic [3:0] channel_cmd_ready_in,
   input wire logic [6:0] vol_old_in,
   input wire logic [6:0] vol_new_in,
   input wire logic [2:0] rate_family_in,
   output slvc_analog_t analog_setup_out,
   output logic spk_amp_on_out,
   output slvc_amp_t line_amp_state_out,
   output logic pop_active_out,
   output logic [3:0] spk_gain_code_out,
   output logic fade_enable_out,
   output logic [2:0] fade_step_code_out,
   output logic [7:0] fade_step_size_out,
   output logic [31:0] fade_time_ns_out,
   output logic wdt_overflow_out,
   output logic osc_stop_out
);

   logic [3:0] busy_n_s1_q, busy_n_s2_q, ready_s1_q, ready_s2_q;
   slvc_parse_t parse_q, parse_d;
   logic [7:0] first_q, step_size_q, step_size_w;
   logic [1:0] skip_q, skip_d;
   slvc_pwr_t pwr_q, pwr_d;
   slvc_amp_t amp_q, amp_d;
   logic [CNT_W-1:0] ramp_cnt_q, ramp_cnt_d, sleep_cnt_q, wdt_cnt_q;
   slvc_analog_t analog_q, analog_d;
   logic spk_on_q, pop_act_q, fade_en_q, fade_en_d, wdt_ovf_q, osc_stop_q;
   logic [3:0] gain_q, gain_d;
   logic [2:0] fade_step_q, fade_step_d;
   logic [31:0] fade_ns_q, fade_ns_w;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   wire [7:0] cmd_byte = bus_wdata_in[7:0];
   wire byte_wr = bus_wr_in && (bus_addr_in == REG_CMD);
   wire standby = (pwr_q == PWR_STANDBY);
   wire all_idle = &busy_n_s2_q;
   wire in_idle = (parse_q == PARSE_IDLE);
   wire in_second = (parse_q == PARSE_SECOND);
   wire ramping = (amp_q == AMP_RISE) || (amp_q == AMP_FALL);
   wire [1:0] extra = slvc_extra_bytes(cmd_byte);
   // First-byte decode; sleep holds the parser still except for wake
   wire take_byte = byte_wr && standby;
   wire wake_go = byte_wr && (pwr_q == PWR_SLEEP) && ((cmd_byte & WAKE_MASK) == WAKE_CODE);
   wire wdt_go = take_byte && in_idle && (cmd_byte == WDT_CODE);
   wire sleep_go = take_byte && in_idle && (cmd_byte == SLEEP_CODE) && all_idle;
   // Second-byte decode
   wire is_analog = ((first_q & ANALOG_MASK) == ANALOG_CODE);
   wire [3:0] gain_field = cmd_byte[GAIN_LSB+3:GAIN_LSB];
   wire gain_ok = ((cmd_byte & GAIN_ZERO_MASK) == 8'h00) &&
                  (gain_field != GAIN_BAD_1) && (gain_field != GAIN_BAD_2);
   wire fade_ok = ((cmd_byte & FADE_ZERO_MASK) == 8'h00);
   wire an_go = take_byte && in_second && is_analog && !ramping && all_idle;
   wire gain_go = take_byte && in_second && (first_q == GAIN_CODE) && gain_ok;
   wire fade_go = take_byte && in_second && (first_q == FADE_CODE) && fade_ok;

   // New analog setup from the two bytes
   wire slvc_analog_t an_new = '{amp_class_select: first_q[1], hpf_on: first_q[0],
                                 fade_on_stop: cmd_byte[7], dac_gain: cmd_byte[6:5],
                                 ain_gain: cmd_byte[4:3], line_amp_enable: cmd_byte[2],
                                 spk_amp_enable: cmd_byte[1], pop_suppress: cmd_byte[0]};
   wire rise_go = an_go && an_new.line_amp_enable && (amp_q == AMP_OFF);
   wire fall_go = an_go && !an_new.line_amp_enable && (amp_q == AMP_ON);
   wire [CNT_W-1:0] rise_len = an_new.pop_suppress ? CNT_W'(SOFT_RISE_CYCLES)
                                                   : CNT_W'(HARD_RISE_CYCLES);
   wire [CNT_W-1:0] fall_len = an_new.pop_suppress ? CNT_W'(SOFT_FALL_CYCLES)
                                                   : CNT_W'(HARD_FALL_CYCLES);
   wire ramp_done = ramping && (ramp_cnt_q <= CNT_W'(1));
   wire sleep_done = (pwr_q == PWR_SLEEP_WAIT) && (sleep_cnt_q <= CNT_W'(1));
   // Watchdog reaches its limit on this edge; a clear in the same cycle loses
   wire wdt_hit = standby && (wdt_cnt_q == CNT_W'(WDT_TIMEOUT_CYCLES - 1));
   // Parser sequencing
   always_comb
   begin
      parse_d = parse_q;
      skip_d = skip_q;
      if (take_byte)
      begin
         unique case (parse_q)
            PARSE_IDLE:
            begin
               if (extra == 2'd1)
                  parse_d = PARSE_SECOND;
               else if (extra == 2'd2)
               begin
                  parse_d = PARSE_SKIP;
                  skip_d = 2'd2;
               end
            end
            PARSE_SECOND:
               parse_d = PARSE_IDLE;
            PARSE_SKIP:
            begin
               skip_d = skip_q - 2'd1;
               if (skip_q == 2'd1)
                  parse_d = PARSE_IDLE;
            end
            default:
               parse_d = PARSE_IDLE;
         endcase
      end
      if (sleep_go)
         parse_d = PARSE_IDLE;
   end

   // Power sequencing
   always_comb
   begin
      pwr_d = pwr_q;
      unique case (pwr_q)
         PWR_STANDBY:
            if (sleep_go)
               pwr_d = PWR_SLEEP_WAIT;
         PWR_SLEEP_WAIT:
            if (sleep_done)
               pwr_d = PWR_SLEEP;
         PWR_SLEEP:
            if (wake_go)
               pwr_d = PWR_STANDBY;
         default:
            pwr_d = PWR_STANDBY;
      endcase
   end

   // Line amplifier ramp; sleep drops it straight to off
   always_comb
   begin
      amp_d = amp_q;
      ramp_cnt_d = ramp_cnt_q;
      if (rise_go)
      begin
         amp_d = AMP_RISE;
         ramp_cnt_d = rise_len;
      end
      else if (fall_go)
      begin
         amp_d = AMP_FALL;
         ramp_cnt_d = fall_len;
      end
      else if (ramp_done)
         amp_d = (amp_q == AMP_RISE) ? AMP_ON : AMP_OFF;
      else if (ramping)
         ramp_cnt_d = ramp_cnt_q - CNT_W'(1);
      if (sleep_go)
      begin
         amp_d = AMP_OFF;
         ramp_cnt_d = '0;
      end
   end
   // Settings update only on complete valid commands; sleep restores defaults
   assign analog_d = sleep_go ? ANALOG_DEFAULT : (an_go ? an_new : analog_q);
   assign gain_d = sleep_go ? GAIN_DEFAULT : (gain_go ? gain_field : gain_q);
   assign fade_en_d = sleep_go ? FADE_EN_DEFAULT : (fade_go ? cmd_byte[0] : fade_en_q);
   assign fade_step_d = sleep_go ? FADE_STEP_DEFAULT :
                        (fade_go ? cmd_byte[3:1] : fade_step_q);

   // Register read selection
   always_comb
   begin
      rdata_d = '0;
      if (bus_rd_in)
      begin
         unique case (bus_addr_in)
            REG_STATUS:
               rdata_d = DATA_W'({ready_s2_q, busy_n_s2_q, osc_stop_q, wdt_ovf_q,
                                  parse_q, amp_q, pwr_q});
            REG_ANALOG:
               rdata_d = DATA_W'({spk_on_q, pop_act_q, analog_q});
            REG_GAIN_FADE:
               rdata_d = DATA_W'({step_size_q, fade_step_q, fade_en_q, gain_q});
            REG_FADE_TIME:
               rdata_d = fade_ns_q;
            REG_WDT:
               rdata_d = wdt_cnt_q;
            default:
               rdata_d = '0;
         endcase
      end
   end

   slvc_fade_timer u_fade_timer (
      .step_code_in(fade_step_q),
      .vol_old_in(vol_old_in),
      .vol_new_in(vol_new_in),
      .rate_family_in(rate_family_in),
      .step_size_out(step_size_w),
      .transition_ns_out(fade_ns_w)
   );
   // Pin synchronisers
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         busy_n_s1_q <= 4'hf;
         busy_n_s2_q <= 4'hf;
         ready_s1_q <= 4'h0;
         ready_s2_q <= 4'h0;
      end
      else
      begin
         busy_n_s1_q <= channel_busy_n_in;
         busy_n_s2_q <= busy_n_s1_q;
         ready_s1_q <= channel_cmd_ready_in;
         ready_s2_q <= ready_s1_q;
      end
   end

   // Sequencing state
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         parse_q <= PARSE_IDLE;
         first_q <= 8'h00;
         skip_q <= 2'd0;
         pwr_q <= PWR_STANDBY;
         amp_q <= AMP_OFF;
         ramp_cnt_q <= '0;
         sleep_cnt_q <= '0;
         osc_stop_q <= 1'b0;
      end
      else
      begin
         parse_q <= parse_d;
         skip_q <= skip_d;
         if (take_byte && in_idle)
            first_q <= cmd_byte;
         pwr_q <= pwr_d;
         amp_q <= amp_d;
         ramp_cnt_q <= ramp_cnt_d;
         sleep_cnt_q <= sleep_go ? CNT_W'(SLEEP_PROC_CYCLES) :
                        ((pwr_q == PWR_SLEEP_WAIT) ? sleep_cnt_q - CNT_W'(1) : sleep_cnt_q);
         osc_stop_q <= (pwr_d == PWR_SLEEP);
      end
   end

   // Settings and watchdog; reset loads their defaults and clears the watchdog
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         analog_q <= ANALOG_DEFAULT;
         gain_q <= GAIN_DEFAULT;
         fade_en_q <= FADE_EN_DEFAULT;
         fade_step_q <= FADE_STEP_DEFAULT;
         spk_on_q <= 1'b0;
         pop_act_q <= 1'b0;
         wdt_cnt_q <= '0;
         wdt_ovf_q <= 1'b0;
      end
      else
      begin
         analog_q <= analog_d;
         gain_q <= gain_d;
         fade_en_q <= fade_en_d;
         fade_step_q <= fade_step_d;
         spk_on_q <= analog_d.spk_amp_enable && !analog_d.line_amp_enable;
         pop_act_q <= analog_d.pop_suppress && analog_d.line_amp_enable;
         if (wdt_go || sleep_go)
            wdt_cnt_q <= '0;
         else if (standby && (wdt_cnt_q != CNT_W'(WDT_TIMEOUT_CYCLES)))
            wdt_cnt_q <= wdt_cnt_q + CNT_W'(1);
         wdt_ovf_q <= wdt_hit || (wdt_ovf_q && !(wdt_go || sleep_go));
      end
   end

   // Fade results and read data
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         step_size_q <= FADE_FULL_STEP;
         fade_ns_q <= 32'h0000_0000;
         rdata_q <= '0;
      end
      else
      begin
         step_size_q <= step_size_w;
         fade_ns_q <= fade_ns_w;
         rdata_q <= rdata_d;
      end
   end

   assign bus_rdata_out = rdata_q;
   assign analog_setup_out = analog_q;
   assign spk_amp_on_out = spk_on_q;
   assign line_amp_state_out = amp_q;
   assign pop_active_out = pop_act_q;
   assign spk_gain_code_out = gain_q;
   assign fade_enable_out = fade_en_q;
   assign fade_step_code_out = fade_step_q;
   assign fade_step_size_out = step_size_q;
   assign fade_time_ns_out = fade_ns_q;
   assign wdt_overflow_out = wdt_ovf_q;
   assign osc_stop_out = osc_stop_q;
endmodule

/* sim/slvc_cmd_core_assertions.sv */
`timescale 1ns/1ps
module slvc_cmd_core_assertions
   import slvc_pkg::*;
#(
   parameter int unsigned SOFT_RISE_CYCLES = 20,
   parameter int unsigned SOFT_FALL_CYCLES = 16,
   parameter int unsigned HARD_RISE_CYCLES = 10,
   parameter int unsigned HARD_FALL_CYCLES = 8
)
(
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic bus_wr_in,
   input wire slvc_analog_t analog_setup_out,
   input wire logic spk_amp_on_out,
   input wire slvc_amp_t line_amp_state_out,
   input wire logic pop_active_out,
   input wire logic [3:0] spk_gain_code_out,
   input wire logic fade_enable_out,
   input wire logic [2:0] fade_step_code_out,
   input wire logic [7:0] fade_step_size_out,
   input wire logic osc_stop_out
);
   slvc_amp_t prev_q;
   logic [31:0] cnt_q;
   logic pop;
   assign pop = analog_setup_out.pop_suppress;
   // Cycles spent in the current line state
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         prev_q <= AMP_OFF;
         cnt_q <= 32'h0;
      end
      else
      begin
         prev_q <= line_amp_state_out;
         cnt_q <= (line_amp_state_out == prev_q) ? cnt_q + 32'h1 : 32'h1;
      end
   end
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!arst_n_in);
   property p_spk_mode;
      spk_amp_on_out == (analog_setup_out.spk_amp_enable && !analog_setup_out.line_amp_enable);
   endproperty
   a_spk_mode: assert property (p_spk_mode)
      else $error("speaker enable wrong");
   property p_pop;
      pop_active_out == (pop && analog_setup_out.line_amp_enable);
   endproperty
   a_pop: assert property (p_pop)
      else $error("pop active wrong");
   property p_step;
      fade_step_size_out == (FADE_FULL_STEP >> $past(fade_step_code_out));
   endproperty
   a_step: assert property (p_step)
      else $error("step size wrong");
   property p_sleep_dflt;
      $rose(osc_stop_out) |-> spk_gain_code_out == GAIN_DEFAULT && !fade_enable_out
         && analog_setup_out == ANALOG_DEFAULT;
   endproperty
   a_sleep_dflt: assert property (p_sleep_dflt)
      else $error("settings kept in sleep");
   property p_write_only;
      ($changed(spk_gain_code_out) || $changed(analog_setup_out) || $changed(fade_enable_out))
         |-> $past(bus_wr_in);
   endproperty
   a_write_only: assert property (p_write_only)
      else $error("setting changed without write");
   property p_rise_line;
      line_amp_state_out == AMP_RISE |-> analog_setup_out.line_amp_enable;
   endproperty
   a_rise_line: assert property (p_rise_line)
      else $error("rise without line enable");
   property p_rise_len;
      (line_amp_state_out == AMP_ON && prev_q == AMP_RISE) |->
         cnt_q + 1 >= (pop ? SOFT_RISE_CYCLES : HARD_RISE_CYCLES)
         && cnt_q <= (pop ? SOFT_RISE_CYCLES : HARD_RISE_CYCLES) + 1;
   endproperty
   a_rise_len: assert property (p_rise_len)
      else $error("rise length wrong");
   property p_fall_len;
      (line_amp_state_out == AMP_OFF && prev_q == AMP_FALL) |->
         cnt_q + 1 >= (pop ? SOFT_FALL_CYCLES : HARD_FALL_CYCLES)
         && cnt_q <= (pop ? SOFT_FALL_CYCLES : HARD_FALL_CYCLES) + 1;
   endproperty
   a_fall_len: assert property (p_fall_len)
      else $error("fall length wrong");
   c_soft_rise: cover property (line_amp_state_out == AMP_ON && prev_q == AMP_RISE && pop);
   c_fall: cover property (line_amp_state_out == AMP_OFF && prev_q == AMP_FALL);
   c_sleep: cover property ($rose(osc_stop_out));
endmodule

/* sim/slvc_host_model.sv */
`timescale 1ns/1ps
module slvc_host_model
   import slvc_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic [DATA_W-1:0] bus_rdata_in,
   output logic [ADDR_W-1:0] bus_addr_out,
   output logic [DATA_W-1:0] bus_wdata_out,
   output logic bus_wr_out,
   output logic bus_rd_out
);
   initial
   begin
      bus_addr_out = 8'h00;
      bus_wdata_out = 32'h0;
      bus_wr_out = 1'b0;
      bus_rd_out = 1'b0;
   end
   // One command byte per strobe, bytes of a command in order
   // Class D never paired with line enable; reserved codes only in refusal
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] b);
      @(posedge sys_clk_in);
      bus_addr_out <= a;
      bus_wdata_out <= {24'h0, b};
      bus_wr_out <= 1'b1;
      @(posedge sys_clk_in);
      bus_wr_out <= 1'b0;
      bus_wdata_out <= ~{24'h0, b};
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge sys_clk_in);
      bus_addr_out <= a;
      bus_rd_out <= 1'b1;
      @(posedge sys_clk_in);
      bus_rd_out <= 1'b0;
      @(negedge sys_clk_in);
      d = bus_rdata_in;
   endtask
endmodule

/* sim/slvc_cmd_core_test.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module slvc_cmd_core_test
   import slvc_pkg::*;
;
   localparam int SR = 20;
   localparam int SF = 16;
   localparam int HR = 10;
   localparam int HF = 8;
   localparam int SP = 5;
   logic sys_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [3:0] channel_busy_n_in = 4'hf;
   logic [3:0] channel_cmd_ready_in = 4'hf;
   logic [2:0] rate_family_in = 3'h0;
   logic [ADDR_W-1:0] bus_addr_in;
   logic [DATA_W-1:0] bus_wdata_in;
   logic [DATA_W-1:0] bus_rdata_out;
   logic bus_wr_in;
   logic bus_rd_in;
   slvc_analog_t analog_setup_out;
   slvc_amp_t line_amp_state_out;
   logic spk_amp_on_out;
   logic pop_active_out;
   logic [3:0] spk_gain_code_out;
   logic fade_enable_out;
   logic [2:0] fade_step_code_out;
   logic [7:0] fade_step_size_out;
   logic [31:0] fade_time_ns_out;
   logic wdt_overflow_out;
   logic osc_stop_out;
   int bad_count = 0;
   int checked = 0;
   int unsigned gns [5] = '{GROUP_NS_0, GROUP_NS_1, GROUP_NS_2, GROUP_NS_3, GROUP_NS_4};
   always #12.5 sys_clk_in = ~sys_clk_in;
   slvc_cmd_core #(
      .SOFT_RISE_CYCLES(SR), .SOFT_FALL_CYCLES(SF), .HARD_RISE_CYCLES(HR),
      .HARD_FALL_CYCLES(HF), .SLEEP_PROC_CYCLES(SP), .WDT_TIMEOUT_CYCLES(100)
   ) u_dut (
      .sys_clk_in, .arst_n_in, .bus_addr_in, .bus_wdata_in, .bus_wr_in, .bus_rd_in,
      .bus_rdata_out, .channel_busy_n_in, .channel_cmd_ready_in,
      .vol_old_in({4'h0, rate_family_in}), .vol_new_in(7'h03), .rate_family_in,
      .analog_setup_out, .spk_amp_on_out,
      .line_amp_state_out, .pop_active_out, .spk_gain_code_out, .fade_enable_out,
      .fade_step_code_out, .fade_step_size_out, .fade_time_ns_out, .wdt_overflow_out,
      .osc_stop_out
   );
   slvc_host_model u_host (
      .sys_clk_in, .bus_rdata_in(bus_rdata_out), .bus_addr_out(bus_addr_in),
      .bus_wdata_out(bus_wdata_in), .bus_wr_out(bus_wr_in), .bus_rd_out(bus_rd_in)
   );
   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask
   task automatic cmd2(input logic [7:0] a, input logic [7:0] b);
      u_host.wr(REG_CMD, a);
      u_host.wr(REG_CMD, b);
      idle(3);
   endtask
   task automatic set_busy(input logic [3:0] v);
      @(posedge sys_clk_in);
      channel_busy_n_in <= v;
      idle(4);
   endtask
   task automatic ramp(input logic [7:0] b, input slvc_amp_t mid, input slvc_amp_t fin, input int n);
      u_host.wr(REG_CMD, ANALOG_CODE);
      u_host.wr(REG_CMD, b);
      idle(n - 2);
      `CHK("ramp_mid", mid, line_amp_state_out)
      idle(5);
      `CHK("ramp_end", fin, line_amp_state_out)
   endtask
   task automatic t_reset();
      logic [31:0] d;
      u_host.rd(REG_GAIN_FADE, d);
      `CHK("rst_gain_fade", 32'h00008008, d)
      u_host.rd(REG_ANALOG, d);
      `CHK("rst_analog", 32'h00000000, d)
      u_host.rd(8'h30, d);
      `CHK("unmapped", 32'h00000000, d)
   endtask
   task automatic t_gain();
      logic [3:0] exp;
      exp = GAIN_DEFAULT;
      @(posedge sys_clk_in);
      channel_cmd_ready_in <= 4'h0;
      for (int c = 15; c >= 0; c--)
      begin
         if (c > 2 || c == 0)
            exp = c[3:0];
         cmd2(GAIN_CODE, {2'b00, c[3:0], 2'b00});
         `CHK("gain", exp, spk_gain_code_out)
      end
      cmd2(GAIN_CODE, 8'h79);
      `CHK("gain_stray", exp, spk_gain_code_out)
      u_host.wr(REG_CMD, 8'hc4);
      cmd2(GAIN_CODE, 8'h38);
      `CHK("gain_skip", exp, spk_gain_code_out)
      cmd2(GAIN_CODE, 8'h38);
      `CHK("gain_e", 4'he, spk_gain_code_out)
   endtask
   task automatic t_fade();
      int dv;
      for (int n = 0; n < 8; n++)
      begin
         @(posedge sys_clk_in);
         rate_family_in <= 3'(n % 5);
         dv = (n % 5 > 3) ? n % 5 - 3 : 3 - n % 5;
         cmd2(FADE_CODE, {4'h0, 3'(n), 1'b1});
         `CHK("fade_en", 1'b1, fade_enable_out)
         `CHK("step", 3'(n), fade_step_code_out)
         `CHK("step_size", 8'h80 >> n, fade_step_size_out)
         `CHK("fade_ns", dv * (((264 << n) + 255) >> 8) * gns[n % 5], fade_time_ns_out)
      end
      cmd2(FADE_CODE, 8'h13);
      `CHK("fade_stray", 3'h7, fade_step_code_out)
      cmd2(FADE_CODE, 8'h00);
      `CHK("fade_off", 1'b0, fade_enable_out)
   endtask
   task automatic t_line();
      ramp(8'h05, AMP_RISE, AMP_ON, SR);
      `CHK("pop_on", 1'b1, pop_active_out)
      ramp(8'h01, AMP_FALL, AMP_OFF, SF);
      u_host.wr(REG_CMD, ANALOG_CODE);
      u_host.wr(REG_CMD, 8'h04);
      cmd2(ANALOG_CODE, 8'h02);
      `CHK("ramp_lock", 10'h004, analog_setup_out)
      idle(HR);
      `CHK("hard_on", AMP_ON, line_amp_state_out)
      ramp(8'h00, AMP_FALL, AMP_OFF, HF);
      set_busy(4'he);
      cmd2(ANALOG_CODE, 8'h02);
      `CHK("busy_lock", 1'b0, spk_amp_on_out)
      set_busy(4'hf);
      cmd2(8'h07, 8'hab);
      `CHK("spk_setup", 10'h3ab, analog_setup_out)
      `CHK("spk_on", 1'b1, spk_amp_on_out)
      `CHK("pop_spk", 1'b0, pop_active_out)
      `CHK("line_idle", AMP_OFF, line_amp_state_out)
      cmd2(ANALOG_CODE, 8'h00);
      `CHK("spk_off", 1'b0, spk_amp_on_out)
   endtask
   task automatic t_wdt();
      logic [31:0] d;
      idle(120);
      `CHK("wdt_ovf", 1'b1, wdt_overflow_out)
      u_host.wr(REG_CMD, WDT_CODE);
      idle(2);
      `CHK("wdt_clr", 1'b0, wdt_overflow_out)
      u_host.rd(REG_WDT, d);
      `CHK("wdt_cnt", 1'b1, d < 32'h8)
   endtask
   task automatic t_sleep();
      set_busy(4'hb);
      u_host.wr(REG_CMD, SLEEP_CODE);
      idle(SP + 6);
      `CHK("sleep_busy", 1'b0, osc_stop_out)
      set_busy(4'hf);
      u_host.wr(REG_CMD, 8'h61);
      idle(2);
      `CHK("gain_stop", 4'he, spk_gain_code_out)
      cmd2(FADE_CODE, 8'h03);
      ramp(8'h04, AMP_RISE, AMP_ON, HR);
      u_host.wr(REG_CMD, SLEEP_CODE);
      idle(SP - 2);
      `CHK("osc_early", 1'b0, osc_stop_out)
      idle(4);
      `CHK("osc_stop", 1'b1, osc_stop_out)
      `CHK("sleep_line", AMP_OFF, line_amp_state_out)
      `CHK("sleep_gain", GAIN_DEFAULT, spk_gain_code_out)
      `CHK("sleep_fade", 1'b0, fade_enable_out)
      cmd2(GAIN_CODE, 8'h38);
      `CHK("sleep_deaf", GAIN_DEFAULT, spk_gain_code_out)
      u_host.wr(REG_CMD, WAKE_CODE);
      idle(2);
      `CHK("wake", 1'b0, osc_stop_out)
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge sys_clk_in);
      arst_n_in <= 1'b1;
      t_reset();
      t_gain();
      t_fade();
      t_line();
      t_wdt();
      t_sleep();
      stop_test();
   end
   initial
   begin
      repeat (20000) @(posedge sys_clk_in);
      bad_count++;
      stop_test();
   end
endmodule
bind slvc_cmd_core slvc_cmd_core_assertions #(
   .SOFT_RISE_CYCLES(SOFT_RISE_CYCLES), .SOFT_FALL_CYCLES(SOFT_FALL_CYCLES),
   .HARD_RISE_CYCLES(HARD_RISE_CYCLES), .HARD_FALL_CYCLES(HARD_FALL_CYCLES)
) u_chk (
   .sys_clk_in, .arst_n_in, .bus_wr_in, .analog_setup_out, .spk_amp_on_out,
   .line_amp_state_out, .pop_active_out, .spk_gain_code_out, .fade_enable_out,
   .fade_step_code_out, .fade_step_size_out, .osc_stop_out
);
